/* cmcb_pkg.sv */
package cmcb_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0]  CMCB_IDX_CONFIG   = 4'h0;
  localparam logic [3:0]  CMCB_IDX_RESERVED = 4'h1;
  localparam logic [3:0]  CMCB_IDX_EXT_E    = 4'hE;
  localparam logic [5:0]  CMCB_ADDR_CONFIG   = 6'h00;
  localparam logic [5:0]  CMCB_ADDR_RESERVED = 6'h04;
  localparam logic [5:0]  CMCB_ADDR_EXT_E    = 6'h38;
  localparam logic [5:0]  CMCB_ADDR_STATUS   = 6'h3C;
  // field positions
  localparam int CMCB_POS_DES_HI  = 7;
  localparam int CMCB_POS_DES_LO  = 5;
  localparam int CMCB_POS_INSEL   = 6;
  localparam int CMCB_POS_TIE     = 5;
  localparam int CMCB_POS_TWOS    = 4;
  localparam int CMCB_POS_TSTAMP  = 3;
  localparam int CMCB_POS_SDR     = 2;
  localparam int CMCB_POS_CLOCK_DRIVEN_IQ   = 6;
  localparam int CMCB_POS_DEMUX   = 7;
  // reset values
  localparam logic [15:0] CMCB_RST_CONFIG   = 16'h2000;
  localparam logic [15:0] CMCB_RST_RESERVED = 16'h2903;
  localparam logic [15:0] CMCB_RST_EXT_E    = 16'h0000;
  localparam logic [1:0]  CMCB_FIXED_LOW    = 2'h0;
  // decoded submode codes for bits 7:5
  localparam logic [2:0]  CMCB_CODE_Q_ONLY  = 3'h6;
  localparam logic [2:0]  CMCB_CODE_TIED    = 3'h5;
  localparam logic [2:0]  CMCB_CODE_CLK_IQ  = 3'h0;

  typedef enum logic [4:0] {
    CMCB_MODE_NONE      = 5'h01,
    CMCB_MODE_I_ONLY    = 5'h02,
    CMCB_MODE_Q_ONLY    = 5'h04,
    CMCB_MODE_TIED      = 5'h08,
    CMCB_MODE_CLK_IQ    = 5'h10
  } cmcb_mode_e;

  typedef struct packed {
    logic       interleave_active;
    logic       input_q;
    logic       inputs_tied;
    logic       twos_complement_select;
    logic       time_stamp_enable;
    logic       single_rate_select;
    logic       illegal_rate_combo;
    cmcb_mode_e mode;
  } cmcb_ctrl_s;
endpackage : cmcb_pkg

/* cmcb_regs.sv */
// Functional notes
// [RULE1] in interleaved mode bit 6 picks the sampled input: 0 I, 1 Q.
// [RULE2] in interleaved mode bit 5 set ties I and Q inputs together.
// [RULE3] submodes decode from bits 7:5 plus bit 6 of register E.
// [RULE4] bit 4 clear gives offset binary, set gives two's complement.
// [RULE5] bit 3 resets to 0, time stamp off; writing 1 enables it.
// [RULE6] bit 2 resets to 0 for dual rate; 1 selects single rate.
// [RULE7] software must not pair dual rate output with 1:2 demux.
// [RULE8] software keeps configuration bits 1:0 at their fixed values.
// [RULE9] software writes only the power-on pattern to reserved word one.
module cmcb_regs
  import cmcb_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // avalon-mm slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [1:0]       response,
  // decoded controls
  output cmcb_ctrl_s       ctrl
);

  logic [15:0] converter_configuration;
  logic [15:0] reserved_word_one;
  logic [15:0] config_ext_e;
  logic        ack;
  cmcb_ctrl_s  next_ctrl;
  cmcb_mode_e  next_mode;

  // one wait state per access so read data comes from a flop
  wire req      = read | write;
  wire hit_cfg  = (address == CMCB_ADDR_CONFIG);
  wire hit_rsv  = (address == CMCB_ADDR_RESERVED);
  wire hit_ext  = (address == CMCB_ADDR_EXT_E);
  wire hit_sts  = (address == CMCB_ADDR_STATUS);
  wire mapped   = hit_cfg | hit_rsv | hit_ext | hit_sts;
  wire wr_go    = write & ack;
  wire [15:0] wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  assign waitrequest = req & ~ack;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [15:0] m);
    merge = (old & ~m) | (wd[15:0] & m);
  endfunction : merge

  wire [2:0] des_bits = converter_configuration[CMCB_POS_DES_HI:CMCB_POS_DES_LO];
  wire       des_on   = converter_configuration[CMCB_POS_DES_HI];
  wire       clk_iq   = config_ext_e[CMCB_POS_CLOCK_DRIVEN_IQ];
  wire       demux    = config_ext_e[CMCB_POS_DEMUX];

  // submode decode
  always_comb begin
    if (des_bits == CMCB_CODE_Q_ONLY && !clk_iq) begin  // [RULE3]
      next_mode = CMCB_MODE_Q_ONLY;
    end else if (des_bits == CMCB_CODE_TIED && !clk_iq) begin  // [RULE3]
      next_mode = CMCB_MODE_TIED;
    end else if (des_bits == CMCB_CODE_CLK_IQ && clk_iq) begin  // [RULE3]
      next_mode = CMCB_MODE_CLK_IQ;
    end else if (des_on) begin
      next_mode = CMCB_MODE_I_ONLY;
    end else begin
      next_mode = CMCB_MODE_NONE;
    end
  end

  always_comb begin
    next_ctrl.mode = next_mode;
    next_ctrl.interleave_active = (next_mode != CMCB_MODE_NONE);
    // input select only matters while bit 7 is set
    next_ctrl.input_q = des_on & converter_configuration[CMCB_POS_INSEL];  // [RULE1]
    next_ctrl.inputs_tied = des_on & converter_configuration[CMCB_POS_TIE];  // [RULE2]
    next_ctrl.twos_complement_select = converter_configuration[CMCB_POS_TWOS];  // [RULE4]
    next_ctrl.time_stamp_enable = converter_configuration[CMCB_POS_TSTAMP];  // [RULE5]
    next_ctrl.single_rate_select = converter_configuration[CMCB_POS_SDR];  // [RULE6]
    // flagged, not blocked: software owns this combination
    next_ctrl.illegal_rate_combo = demux & ~converter_configuration[CMCB_POS_SDR];  // [RULE7]
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      converter_configuration <= CMCB_RST_CONFIG;  // [RULE5] [RULE6]
      reserved_word_one       <= CMCB_RST_RESERVED;
      config_ext_e            <= CMCB_RST_EXT_E;
    end else if (wr_go) begin
      if (hit_cfg) begin
        converter_configuration <= merge(converter_configuration, writedata, wmask);
      end
      // stored as written; holding the pattern is software's duty
      if (hit_rsv) begin
        reserved_word_one <= merge(reserved_word_one, writedata, wmask);  // [RULE9]
      end
      if (hit_ext) begin
        config_ext_e <= merge(config_ext_e, writedata, wmask);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0000_0000;
      response <= 2'h0;
      ctrl     <= '{default: 1'b0, mode: CMCB_MODE_NONE};
    end else begin
      ctrl <= next_ctrl;
      if (req && !ack) begin
        response <= mapped ? 2'h0 : 2'h3;
        if (hit_cfg) begin
          // bits 1:0 read back as held; software keeps them fixed
          readdata <= {16'h0000, converter_configuration};  // [RULE8]
        end else if (hit_rsv) begin
          readdata <= {16'h0000, reserved_word_one};
        end else if (hit_ext) begin
          readdata <= {16'h0000, config_ext_e};
        end else if (hit_sts) begin
          readdata <= {16'h0000, 4'h0, next_ctrl.illegal_rate_combo,
                       next_ctrl.mode, next_ctrl.interleave_active,
                       next_ctrl.input_q, next_ctrl.inputs_tied,
                       next_ctrl.twos_complement_select,
                       next_ctrl.time_stamp_enable, next_ctrl.single_rate_select};
        end else begin
          readdata <= 32'h0000_0000;
        end
      end
    end
  end

endmodule : cmcb_regs

/* cmcb_regs_properties.sv */
module cmcb_regs_properties
  import cmcb_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // bus
  input wire logic [5:0]  address,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  // controls
  input wire cmcb_ctrl_s  ctrl
);
  logic [7:0] c;
  logic       e6;
  logic       e7;
  logic [9:0] xp;
  logic [4:0] m;
  logic [9:0] x;
  wire        wr_ok = write & ~waitrequest & byteenable[0];
  // only the low lane holds the decoded fields
  assign m = (c[7:5] == CMCB_CODE_Q_ONLY && !e6) ? CMCB_MODE_Q_ONLY :
             (c[7:5] == CMCB_CODE_TIED && !e6) ? CMCB_MODE_TIED :
             (c[7:5] == CMCB_CODE_CLK_IQ && e6) ? CMCB_MODE_CLK_IQ :
             c[7] ? CMCB_MODE_I_ONLY : CMCB_MODE_NONE;
  assign x = {c[7] & c[6], c[7] & c[5], c[4], c[3], c[2], m};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c <= CMCB_RST_CONFIG[7:0];
      e6 <= 1'b0;
      e7 <= 1'b0;
      xp <= 10'h001;
    end else begin
      if (wr_ok && address == CMCB_ADDR_CONFIG) c <= writedata[7:0];
      if (wr_ok && address == CMCB_ADDR_EXT_E) e6 <= writedata[CMCB_POS_CLOCK_DRIVEN_IQ];
      if (wr_ok && address == CMCB_ADDR_EXT_E) e7 <= writedata[CMCB_POS_DEMUX];
      xp <= x;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_input_pick: assert property (ctrl.input_q == xp[9])
    else $error("input select wrong");
  chk_tie_inputs: assert property (ctrl.inputs_tied == xp[8])
    else $error("input tie wrong");
  chk_mode_decode: assert property (ctrl.mode == xp[4:0])
    else $error("submode wrong");
  chk_twos_format: assert property (ctrl.twos_complement_select == xp[7])
    else $error("format wrong");
  chk_stamp_enable: assert property (ctrl.time_stamp_enable == xp[6])
    else $error("time stamp wrong");
  chk_rate_combo: assert property (ctrl.illegal_rate_combo == $past(e7 & ~c[2]))
    else $error("rate combination flag wrong");
  chk_rate_select: assert property (ctrl.single_rate_select == xp[5])
    else $error("rate select wrong");
endmodule : cmcb_regs_properties

bind cmcb_regs cmcb_regs_properties u_chk (.clk, .rst_b, .address, .write, .writedata,
  .byteenable, .waitrequest, .ctrl);

/* cmcb_regs_bench.sv */
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module cmcb_regs_bench
  import cmcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0;
  logic [5:0]  address = 6'h00;
  logic [31:0] writedata = 32'h0, readdata, rdat;
  logic [3:0]  byteenable = 4'hF;
  logic [1:0]  response, rresp;
  logic        waitrequest;
  cmcb_ctrl_s  ctrl;
  int          compares = 0, n_mismatch = 0, cyc = 0;
  logic [7:0]  tc [6] = '{8'hC0, 8'hA0, 8'h80, 8'h1C, 8'h00, 8'hE0};
  logic [9:0]  tx [6] = '{10'h204, 10'h108, 10'h002, 10'h0E1, 10'h010, 10'h302};
  cmcb_regs DUT (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .ctrl(ctrl));
  always #5 clk = ~clk;
  task give_verdict;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // request held until the rising edge that sees waitrequest low
  task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {16'h0000, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    rdat = readdata;
    rresp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc
  task automatic rd(input logic [5:0] a, input logic [15:0] e, input logic [1:0] r);
    acc(1'b0, a, 16'h0000);
    `CHK(rdat, {16'h0000, e})
    `CHK(rresp, r)
  endtask : rd
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(CMCB_ADDR_CONFIG, CMCB_RST_CONFIG, 2'h0);
    rd(CMCB_ADDR_RESERVED, CMCB_RST_RESERVED, 2'h0);
    acc(1'b1, CMCB_ADDR_RESERVED, CMCB_RST_RESERVED);
    rd(6'h08, 16'h0000, 2'h3);
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, CMCB_ADDR_EXT_E, (i == 4) ? 16'h0040 : 16'h0000);
      acc(1'b1, CMCB_ADDR_CONFIG, {8'h20, tc[i]});
      @(posedge clk);
      @(negedge clk);
      `CHK({ctrl.input_q, ctrl.inputs_tied, ctrl.twos_complement_select, ctrl.time_stamp_enable, ctrl.single_rate_select, ctrl.mode}, tx[i])
      rd(CMCB_ADDR_CONFIG, {8'h20, tc[i]}, 2'h0);
      rd(CMCB_ADDR_STATUS, {4'h0, 1'b0, tx[i][4:0], (i != 3), tx[i][9:5]}, 2'h0);
    end
    acc(1'b1, CMCB_ADDR_EXT_E, 16'h0080);
    rd(CMCB_ADDR_STATUS, {4'h0, 1'b1, tx[5][4:0], 1'b1, tx[5][9:5]}, 2'h0);
    give_verdict;
  end
endmodule : cmcb_regs_bench
